// >>> acrc_pkg.sv
// Package: register map, fields, codes and timing for the converter control block
package acrc_pkg;
   // Register byte addresses (APB word aligned)
   localparam logic [7:0] ADDR_CTRL_FIRST = 8'h00;
   localparam logic [7:0] ADDR_CTRL_SECOND = 8'h04;
   localparam logic [7:0] ADDR_CTRL_THIRD = 8'h08;
   localparam logic [7:0] ADDR_RESULT_HIGH = 8'h0C;
   localparam logic [7:0] ADDR_RESULT_LOW = 8'h10;
   localparam logic [7:0] ADDR_REF_TEMP = 8'h14;
   localparam logic [7:0] ADDR_FLAGS = 8'h18;
   // converter_control_first fields
   localparam int CF_ENABLE_BIT = 0;
   localparam int CF_GO_BIT = 1;
   localparam int CF_CHAN_LSB = 2;
   localparam int CHAN_W = 5;
   // converter_control_second fields
   localparam int CS_PREF_LSB = 0;
   localparam int PREF_W = 2;
   localparam int CS_NREF_BIT = 2;
   // converter_control_third fields
   localparam int CT_NCHAN_LSB = 0;
   localparam int NCHAN_W = 4;
   localparam logic [3:0] NCHAN_SINGLE_ENDED = 4'hF;
   // reference_temp_control fields
   localparam int RT_FVR_GAIN_LSB = 0;
   localparam int RT_CMP_GAIN_LSB = 2;
   localparam int RT_TS_RANGE_BIT = 4;
   localparam int RT_TS_ENABLE_BIT = 5;
   localparam int RT_FVR_READY_BIT = 6;
   localparam int RT_FVR_ENABLE_BIT = 7;
   // flags register
   localparam int FL_DONE_BIT = 0;
   localparam int FL_WAKE_BIT = 1;
   // Positive channel codes
   localparam logic [4:0] CHAN_TEMP = 5'h1D;
   localparam logic [4:0] CHAN_DAC = 5'h1E;
   localparam logic [4:0] CHAN_FVR = 5'h1F;
   localparam logic [4:0] CHAN_PIN_LAST = 5'h0D;
   localparam logic [4:0] CHAN_PIN_GAP_LO = 5'h05;
   localparam logic [4:0] CHAN_PIN_GAP_HI = 5'h07;
   // Reference codes
   localparam logic [1:0] PREF_SUPPLY = 2'h0;
   localparam logic [1:0] PREF_PIN = 2'h2;
   localparam logic [1:0] PREF_FVR = 2'h3;
   localparam logic NREF_GROUND = 1'b0;
   localparam logic NREF_PIN = 1'b1;
   // Conversion timing
   localparam int RESULT_W = 12;
   localparam int CONV_PERIODS = 15;
   localparam int CLK_MHZ = 25;
   localparam int FVR_SETTLE_US = 30;
   localparam int FVR_SETTLE_CYCLES = FVR_SETTLE_US * CLK_MHZ;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   typedef enum logic [1:0] {ACRC_IDLE, ACRC_SAMPLE, ACRC_BITS, ACRC_DONE} acrc_state_type;
endpackage : acrc_pkg

// >>> acrc_sar.sv
// Successive approximation sequencer: one bit per conversion period
module acrc_sar
   import acrc_pkg::*;
#(
   parameter int WIDTH = RESULT_W,
   parameter int DIV = 4
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic start,
   input wire logic abort,
   input wire logic cmp_high,
   output logic [WIDTH-1:0] trial,
   output logic [WIDTH-1:0] result,
   output logic sample,
   output logic done
);
   localparam int DIV_W = $clog2(DIV + 1);
   localparam int STEP_W = $clog2(CONV_PERIODS + 1);
   acrc_state_type state;
   logic [DIV_W-1:0] div_cnt;
   logic [STEP_W-1:0] step;
   logic [WIDTH-1:0] bitmask;
   wire tick = (div_cnt == DIV_W'(DIV - 1));
   wire last_bit = bitmask[0];
   wire [WIDTH-1:0] next_trial = cmp_high ? trial : (trial & ~bitmask);

   always_ff @(posedge clk) begin
      if (!rstn || abort || start) begin
         div_cnt <= '0;
      end else if (tick) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + DIV_W'(1);
      end
   end

   // Periods: sample phase, 12 bit decisions, then finish (15 in all)
   always_ff @(posedge clk) begin
      done <= 1'b0;
      if (!rstn || abort) begin
         state <= ACRC_IDLE;
         step <= '0;
         bitmask <= '0;
         trial <= '0;
         result <= '0;
         sample <= 1'b0;
      end else begin
         case (state)
            ACRC_IDLE: begin
               if (start) begin
                  state <= ACRC_SAMPLE;
                  step <= '0;
                  sample <= 1'b1;
               end
            end
            ACRC_SAMPLE: begin
               if (tick) begin
                  step <= step + STEP_W'(1);
                  if (step == STEP_W'(CONV_PERIODS - WIDTH - 2)) begin
                     sample <= 1'b0;
                     state <= ACRC_BITS;
                     bitmask <= {1'b1, {(WIDTH-1){1'b0}}};
                     trial <= {1'b1, {(WIDTH-1){1'b0}}};
                  end
               end
            end
            ACRC_BITS: begin
               if (tick) begin
                  step <= step + STEP_W'(1);
                  trial <= next_trial | (bitmask >> 1);
                  bitmask <= bitmask >> 1;
                  if (last_bit) begin
                     result <= next_trial;
                     state <= ACRC_DONE;
                  end
               end
            end
            ACRC_DONE: begin
               if (tick) begin
                  done <= 1'b1;
                  state <= ACRC_IDLE;
               end
            end
            default: state <= ACRC_IDLE;
         endcase
      end
   end
endmodule : acrc_sar

// >>> acrc_top.sv
// Converter channel, reference and temperature sensor control with APB registers
// Function
// (R1) SAR gives a 12-bit result stored in high and low result bytes.
// (R2) Conversion completion raises an interrupt request.
// (R3) Completion interrupt can wake the device from sleep.
// (R4) Fourteen positive sources: pins 13-8, 4-0, temp sensor, DAC, fixed reference.
// (R5) Four-bit negative field selects negative input; any pairing allowed.
// (R6) Negative field all ones means single-ended conversion.
// (R7) Five-bit positive field in first control register selects sample-hold input.
// (R8) Software waits a settling delay after a channel change.
// (R9) Positive reference: external pin, supply or fixed-reference buffer.
// (R10) Negative reference: external pin or ground.
// (R11) Temp sensor powered only while enable bit 5 is set.
// (R12) Range bit 4 selects high range when set, low when clear.
// (R13) One channel dedicated to the internally routed temp sensor.
// (R14) Software waits 200 us after selecting temp sensor before converting.
// (R15) Software leaves 200 us between successive temp sensor conversions.
// (R16) Software sets pins to analog input before converting them.
// (R17) Writing go clears both result bytes and starts a conversion.
// (R18) On completion go clears and the done flag sets.
// (R19) A full conversion takes 15 conversion periods.
// (R20) Clearing go early discards partial result, keeps previous result; result bytes here stay zero, as cleared by the go write.
// (R21) Channel and reference codes fixed in one table.
module acrc_top
   import acrc_pkg::*;
#(
   parameter int CONV_DIV = 4
) (
   input wire logic CORE_CLK,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic SLEEP_MODE,
   input wire logic CMP_HIGH,
   output logic [RESULT_W-1:0] DAC_TRIAL,
   output logic SAMPLE_HOLD,
   output logic [CHAN_W-1:0] POS_MUX,
   output logic [NCHAN_W-1:0] NEG_MUX,
   output logic SINGLE_ENDED,
   output logic [PREF_W-1:0] POS_REF_MUX,
   output logic NEG_REF_MUX,
   output logic TEMP_SENSOR_POWER,
   output logic TEMP_RANGE_HIGH,
   output logic [1:0] CONV_REF_GAIN,
   output logic [1:0] CMP_REF_GAIN,
   output logic FIXED_REF_ENABLE,
   output logic CONV_IRQ,
   output logic WAKE
);
   // Synchronised pin inputs
   logic cmp_meta;
   logic cmp_sync;
   logic sleep_meta;
   logic sleep_sync;

   // Software-visible state
   logic conv_enable;
   logic go;
   logic [CHAN_W-1:0] positive_channel_select;
   logic [PREF_W-1:0] positive_ref_select;
   logic negative_ref_select;
   logic [NCHAN_W-1:0] negative_channel_select;
   logic [7:0] result_high_byte;
   logic [7:0] result_low_byte;
   logic fixed_reference_enable;
   logic fixed_reference_ready;
   logic temp_sensor_enable;
   logic temp_range_high;
   logic [1:0] comparator_ref_gain;
   logic [1:0] converter_ref_gain;
   logic conversion_done_flag;
   logic wake_flag;
   logic [$clog2(FVR_SETTLE_CYCLES + 1)-1:0] fvr_cnt;

   // SAR core outputs
   logic [RESULT_W-1:0] sar_trial;
   logic [RESULT_W-1:0] sar_result;
   logic sar_sample;
   logic sar_done;

   // Bus decode
   wire access_phase = PSEL && PENABLE;
   wire wr = access_phase && PWRITE;
   wire hit_first = (PADDR == ADDR_CTRL_FIRST);
   wire hit_second = (PADDR == ADDR_CTRL_SECOND);
   wire hit_third = (PADDR == ADDR_CTRL_THIRD);
   wire hit_high = (PADDR == ADDR_RESULT_HIGH);
   wire hit_low = (PADDR == ADDR_RESULT_LOW);
   wire hit_ref = (PADDR == ADDR_REF_TEMP);
   wire hit_flags = (PADDR == ADDR_FLAGS);
   wire hit_any = hit_first || hit_second || hit_third || hit_high || hit_low || hit_ref || hit_flags;
   wire wr_first = wr && hit_first;
   wire wr_flags = wr && hit_flags;

   // Go edge and early clear
   wire go_write_set = wr_first && PWDATA[CF_GO_BIT] && PWDATA[CF_ENABLE_BIT] && conv_enable;
   wire go_write_clr = wr_first && !PWDATA[CF_GO_BIT];
   wire start_conv = go_write_set && !go;
   wire abort_conv = go && (go_write_clr || (wr_first && !PWDATA[CF_ENABLE_BIT]));
   wire conv_complete = sar_done && go && !abort_conv;

   // Result split: top four bits in the high byte, low eight in the low byte
   wire [7:0] next_result_high = {{(16 - RESULT_W){1'b0}}, sar_result[RESULT_W-1:8]};
   wire [7:0] next_result_low = sar_result[7:0];

   // Channel legality table
   wire pos_is_pin = (positive_channel_select <= CHAN_PIN_LAST) &&
      !((positive_channel_select >= CHAN_PIN_GAP_LO) && (positive_channel_select <= CHAN_PIN_GAP_HI));
   wire pos_is_internal = (positive_channel_select == CHAN_TEMP) || (positive_channel_select == CHAN_DAC) ||
      (positive_channel_select == CHAN_FVR);
   wire pos_valid = pos_is_pin || pos_is_internal;

   // Read mux
   wire [7:0] rd_first = {1'b0, positive_channel_select, go, conv_enable};
   wire [7:0] rd_second = {5'h00, negative_ref_select, positive_ref_select};
   wire [7:0] rd_third = {4'h0, negative_channel_select};
   wire [7:0] rd_ref = {fixed_reference_enable, fixed_reference_ready, temp_sensor_enable, temp_range_high,
      comparator_ref_gain, converter_ref_gain};
   wire [7:0] rd_flags = {5'h00, pos_valid, wake_flag, conversion_done_flag};
   wire [7:0] rd_byte = hit_first ? rd_first :
                        hit_second ? rd_second :
                        hit_third ? rd_third :
                        hit_high ? result_high_byte :
                        hit_low ? result_low_byte :
                        hit_ref ? rd_ref :
                        hit_flags ? rd_flags : RESET_BYTE;

   acrc_sar #(
      .WIDTH(RESULT_W),
      .DIV(CONV_DIV)
   ) u_sar (
      .clk(CORE_CLK),
      .rstn(RSTN),
      .start(start_conv), // see (R19)
      .abort(abort_conv),
      .cmp_high(cmp_sync),
      .trial(sar_trial),
      .result(sar_result), // see (R1)
      .sample(sar_sample),
      .done(sar_done)
   );

   always_ff @(posedge CORE_CLK) begin
      cmp_meta <= CMP_HIGH;
      cmp_sync <= cmp_meta;
      sleep_meta <= SLEEP_MODE;
      sleep_sync <= sleep_meta;
   end

   // APB slave: zero wait states, error on unmapped address
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         PRDATA <= RESET_WORD;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= PSEL && !PENABLE;
         PSLVERR <= PSEL && !PENABLE && !hit_any;
         PRDATA <= (PSEL && !PENABLE && !PWRITE) ? {24'h000000, rd_byte} : RESET_WORD;
      end
   end

   // Write and access only in the access phase with PREADY high
   wire wr_ok = wr && PREADY;

   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         conv_enable <= 1'b0;
         positive_channel_select <= '0;
         positive_ref_select <= PREF_SUPPLY;
         negative_ref_select <= NREF_GROUND;
         negative_channel_select <= NCHAN_SINGLE_ENDED;
      end else begin
         if (wr_ok && hit_first) begin
            conv_enable <= PWDATA[CF_ENABLE_BIT];
            positive_channel_select <= PWDATA[CF_CHAN_LSB +: CHAN_W]; // see (R7) see (R4) see (R13)
         end
         if (wr_ok && hit_second) begin
            positive_ref_select <= PWDATA[CS_PREF_LSB +: PREF_W]; // see (R9)
            negative_ref_select <= PWDATA[CS_NREF_BIT]; // see (R10)
         end
         if (wr_ok && hit_third) begin
            negative_channel_select <= PWDATA[CT_NCHAN_LSB +: NCHAN_W]; // see (R5)
         end
      end
   end

   // Go flag and result bytes
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         go <= 1'b0;
         result_high_byte <= RESET_BYTE;
         result_low_byte <= RESET_BYTE;
      end else if (conv_complete) begin
         go <= 1'b0; // see (R18)
         result_high_byte <= next_result_high; // see (R1)
         result_low_byte <= next_result_low;
      end else if (start_conv && wr_ok) begin
         go <= 1'b1; // see (R17)
         result_high_byte <= RESET_BYTE;
         result_low_byte <= RESET_BYTE;
      end else if (abort_conv && wr_ok) begin
         go <= 1'b0; // see (R20)
      end
   end

   // Reference and temperature sensor control
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         fixed_reference_enable <= 1'b0;
         temp_sensor_enable <= 1'b0;
         temp_range_high <= 1'b0;
         comparator_ref_gain <= 2'h0;
         converter_ref_gain <= 2'h0;
      end else if (wr_ok && hit_ref) begin
         fixed_reference_enable <= PWDATA[RT_FVR_ENABLE_BIT];
         temp_sensor_enable <= PWDATA[RT_TS_ENABLE_BIT]; // see (R11)
         temp_range_high <= PWDATA[RT_TS_RANGE_BIT]; // see (R12)
         comparator_ref_gain <= PWDATA[RT_CMP_GAIN_LSB +: 2];
         converter_ref_gain <= PWDATA[RT_FVR_GAIN_LSB +: 2];
      end
   end

   // Fixed reference ready after settling count
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN || !fixed_reference_enable) begin
         fvr_cnt <= '0;
         fixed_reference_ready <= 1'b0;
      end else if (fvr_cnt == $bits(fvr_cnt)'(FVR_SETTLE_CYCLES)) begin
         fixed_reference_ready <= 1'b1;
      end else begin
         fvr_cnt <= fvr_cnt + $bits(fvr_cnt)'(1);
      end
   end

   // Done flag: set wins over software clear (write one to clear)
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         conversion_done_flag <= 1'b0;
         wake_flag <= 1'b0;
      end else begin
         if (conv_complete) begin
            conversion_done_flag <= 1'b1; // see (R2) see (R18)
         end else if (wr_ok && wr_flags && PWDATA[FL_DONE_BIT]) begin
            conversion_done_flag <= 1'b0;
         end
         if (conv_complete && sleep_sync) begin
            wake_flag <= 1'b1; // see (R3)
         end else if (wr_ok && wr_flags && PWDATA[FL_WAKE_BIT]) begin
            wake_flag <= 1'b0;
         end
      end
   end

   // Analog side outputs, all registered
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         DAC_TRIAL <= '0;
         SAMPLE_HOLD <= 1'b0;
         POS_MUX <= '0;
         NEG_MUX <= NCHAN_SINGLE_ENDED;
         SINGLE_ENDED <= 1'b1;
         POS_REF_MUX <= PREF_SUPPLY;
         NEG_REF_MUX <= NREF_GROUND;
         TEMP_SENSOR_POWER <= 1'b0;
         TEMP_RANGE_HIGH <= 1'b0;
         CONV_REF_GAIN <= 2'h0;
         CMP_REF_GAIN <= 2'h0;
         FIXED_REF_ENABLE <= 1'b0;
         CONV_IRQ <= 1'b0;
         WAKE <= 1'b0;
      end else begin
         DAC_TRIAL <= sar_trial;
         SAMPLE_HOLD <= sar_sample && conv_enable;
         POS_MUX <= positive_channel_select; // see (R21)
         NEG_MUX <= negative_channel_select;
         SINGLE_ENDED <= (negative_channel_select == NCHAN_SINGLE_ENDED); // see (R6)
         POS_REF_MUX <= positive_ref_select;
         NEG_REF_MUX <= negative_ref_select;
         TEMP_SENSOR_POWER <= temp_sensor_enable; // see (R11)
         TEMP_RANGE_HIGH <= temp_range_high; // see (R12)
         CONV_REF_GAIN <= converter_ref_gain;
         CMP_REF_GAIN <= comparator_ref_gain;
         FIXED_REF_ENABLE <= fixed_reference_enable;
         CONV_IRQ <= conversion_done_flag; // see (R2)
         WAKE <= wake_flag; // see (R3)
      end
   end
endmodule : acrc_top

// >>> acrc_assertions.sv
// Port-level checker for the converter control block
module acrc_checker
   import acrc_pkg::*;
#(
   parameter int CONV_DIV = 4
) (
   input wire logic CORE_CLK,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic PREADY,
   input wire logic SLEEP_MODE,
   input wire logic SAMPLE_HOLD,
   input wire logic [CHAN_W-1:0] POS_MUX,
   input wire logic [NCHAN_W-1:0] NEG_MUX,
   input wire logic SINGLE_ENDED,
   input wire logic [PREF_W-1:0] POS_REF_MUX,
   input wire logic NEG_REF_MUX,
   input wire logic TEMP_SENSOR_POWER,
   input wire logic TEMP_RANGE_HIGH,
   input wire logic CONV_IRQ,
   input wire logic WAKE
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int CONV_MIN = 15 * CONV_DIV - 2;
   localparam int CONV_MAX = 15 * CONV_DIV + 4;
   logic [7:0] q_first, q_second, q_third, q_ref;
   logic busy, irq_q;
   logic [9:0] cnt;
   wire wr_any = PSEL && PENABLE && PREADY && PWRITE;
   wire wr_first = wr_any && (PADDR == ADDR_CTRL_FIRST);
   wire go_start = wr_first && (PWDATA[1:0] == 2'h3) && !busy;
   wire go_stop = wr_first && busy && (PWDATA[1:0] != 2'h3);
   // Shadow copies of written registers and a conversion cycle count
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         q_first <= 8'h00;
         q_second <= 8'h00;
         q_third <= 8'h0F;
         q_ref <= 8'h00;
         busy <= 1'b0;
         irq_q <= 1'b0;
         cnt <= 10'h000;
      end else begin
         if (wr_first) q_first <= PWDATA[7:0];
         if (wr_any && PADDR == ADDR_CTRL_SECOND) q_second <= PWDATA[7:0];
         if (wr_any && PADDR == ADDR_CTRL_THIRD) q_third <= PWDATA[7:0];
         if (wr_any && PADDR == ADDR_REF_TEMP) q_ref <= PWDATA[7:0];
         irq_q <= CONV_IRQ;
         cnt <= go_start ? 10'h000 : cnt + 10'h001;
         busy <= go_start || (busy && !go_stop && !(CONV_IRQ && !irq_q));
      end
   end
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RSTN);
   sequence s_go;
      go_start;
   endsequence
   sequence s_sampling;
      ##[1:3] SAMPLE_HOLD;
   endsequence
   property p_start;
      s_go |-> s_sampling;
   endproperty
   a_start: assert property (p_start) else $error("no sample phase after start");
   property p_len;
      $rose(CONV_IRQ) |-> busy && cnt >= CONV_MIN && cnt <= CONV_MAX;
   endproperty
   a_len: assert property (p_len) else $error("conversion length wrong");
   property p_abort;
      go_stop |-> ##2 (!CONV_IRQ && !SAMPLE_HOLD) [*8];
   endproperty
   a_abort: assert property (p_abort) else $error("aborted conversion went on");
   property p_wake;
      $rose(WAKE) |-> $rose(CONV_IRQ) && SLEEP_MODE;
   endproperty
   a_wake: assert property (p_wake) else $error("wake without completion in sleep");
   property p_pos_mux;
      $past(wr_any, 2) |-> POS_MUX == q_first[6:2];
   endproperty
   a_pos_mux: assert property (p_pos_mux) else $error("positive mux mismatch");
   property p_neg_mux;
      $past(wr_any, 2) |-> NEG_MUX == q_third[3:0];
   endproperty
   a_neg_mux: assert property (p_neg_mux) else $error("negative mux mismatch");
   property p_single;
      SINGLE_ENDED == (NEG_MUX == NCHAN_SINGLE_ENDED);
   endproperty
   a_single: assert property (p_single) else $error("single-ended flag wrong");
   property p_refs;
      $past(wr_any, 2) |-> POS_REF_MUX == q_second[1:0] && NEG_REF_MUX == q_second[2];
   endproperty
   a_refs: assert property (p_refs) else $error("reference select mismatch");
   property p_ts;
      $changed(TEMP_SENSOR_POWER) |-> TEMP_SENSOR_POWER == q_ref[5] && ($past(wr_any) || $past(wr_any, 2));
   endproperty
   a_ts: assert property (p_ts) else $error("sensor power change unexplained");
   property p_range;
      $past(wr_any, 2) |-> TEMP_RANGE_HIGH == q_ref[4];
   endproperty
   a_range: assert property (p_range) else $error("sensor range mismatch");
   property p_ready;
      PSEL && !PENABLE |=> PREADY ##1 !PREADY;
   endproperty
   a_ready: assert property (p_ready) else $error("ready not one cycle after setup");
endmodule : acrc_checker

bind acrc_top acrc_checker #(.CONV_DIV(CONV_DIV)) i_chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
   .SLEEP_MODE(SLEEP_MODE), .SAMPLE_HOLD(SAMPLE_HOLD), .POS_MUX(POS_MUX), .NEG_MUX(NEG_MUX),
   .SINGLE_ENDED(SINGLE_ENDED), .POS_REF_MUX(POS_REF_MUX), .NEG_REF_MUX(NEG_REF_MUX),
   .TEMP_SENSOR_POWER(TEMP_SENSOR_POWER), .TEMP_RANGE_HIGH(TEMP_RANGE_HIGH), .CONV_IRQ(CONV_IRQ), .WAKE(WAKE));

// >>> acrc_analog_model.sv
// Behavioural analog core: input mux, sample-hold and comparator
module acrc_analog_model
   import acrc_pkg::*;
#(
   parameter logic [6:0] LEVEL_LOW = 7'h2D
) (
   input wire logic clk,
   input wire logic [RESULT_W-1:0] trial,
   input wire logic sample,
   input wire logic [CHAN_W-1:0] pos_sel,
   input wire logic [NCHAN_W-1:0] neg_sel,
   input wire logic single,
   output logic cmp_high
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [RESULT_W-1:0] held = 12'hA5A;
   // Every channel code, sensor included, has its own level; pins taken as analog inputs
   wire [RESULT_W-1:0] pos_level = {pos_sel, LEVEL_LOW};
   wire [RESULT_W-1:0] neg_level = single ? 12'h000 : {4'h0, neg_sel, 4'h0};
   always_ff @(posedge clk) begin
      if (sample) held <= pos_level - neg_level;
   end
   assign cmp_high = held >= trial;
endmodule : acrc_analog_model

// >>> acrc_tb_top.sv
// Self-checking bench for the converter control block
module acrc_tb_top
   import acrc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(what, exp, act) \
   begin \
      cmp_count++; \
      if ((act) !== (exp)) begin \
         miscompares++; \
         $display("wrong value %s expected %0h seen %0h", what, exp, act); \
      end \
   end
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [7:0] rd; logic err; logic [14:0] port;} acrc_row_type;
   logic clk, rstn, psel, penable, pwrite, pready, pslverr, sleep_mode, cmp_high, sample_hold;
   logic single_ended, neg_ref_mux, ts_power, range_high, fvr_en, conv_irq, wake, rerr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [11:0] dac_trial;
   logic [4:0] pos_mux;
   logic [3:0] neg_mux;
   logic [1:0] pos_ref_mux, conv_gain, cmp_gain;
   int miscompares = 0;
   int cmp_count = 0;
   int cycles = 0;
   wire [14:0] port_vec = {pos_mux, pos_ref_mux, neg_ref_mux, single_ended, ts_power, range_high, conv_gain, cmp_gain};
   acrc_row_type rows [10] = '{'{8'h00, 32'h75, 8'h75, 1'b0, 15'h7440}, '{8'h04, 32'h2, 8'h02, 1'b0, 15'h7640},
      '{8'h04, 32'h7, 8'h07, 1'b0, 15'h77C0}, '{8'h04, 32'h0, 8'h00, 1'b0, 15'h7440},
      '{8'h08, 32'hABCD_0003, 8'h03, 1'b0, 15'h7400}, '{8'h08, 32'hF, 8'h0F, 1'b0, 15'h7440},
      '{8'h14, 32'h3F, 8'h3F, 1'b0, 15'h747F}, '{8'h14, 32'h0, 8'h00, 1'b0, 15'h7440},
      '{8'h0C, 32'hFF, 8'h00, 1'b0, 15'h7440}, '{8'h1C, 32'h55, 8'h00, 1'b1, 15'h7440}};
   logic [4:0] chans [14] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D,
      CHAN_TEMP, CHAN_DAC, CHAN_FVR};
   acrc_top #(.CONV_DIV(4)) i_dut (.CORE_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SLEEP_MODE(sleep_mode),
      .CMP_HIGH(cmp_high), .DAC_TRIAL(dac_trial), .SAMPLE_HOLD(sample_hold), .POS_MUX(pos_mux), .NEG_MUX(neg_mux),
      .SINGLE_ENDED(single_ended), .POS_REF_MUX(pos_ref_mux), .NEG_REF_MUX(neg_ref_mux), .TEMP_SENSOR_POWER(ts_power),
      .TEMP_RANGE_HIGH(range_high), .CONV_REF_GAIN(conv_gain), .CMP_REF_GAIN(cmp_gain), .FIXED_REF_ENABLE(fvr_en),
      .CONV_IRQ(conv_irq), .WAKE(wake));
   acrc_analog_model i_model (.clk(clk), .trial(dac_trial), .sample(sample_hold), .pos_sel(pos_mux),
      .neg_sel(neg_mux), .single(single_ended), .cmp_high(cmp_high));
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic convert(input logic [4:0] ch, input logic [11:0] exp);
      int n;
      n = 0;
      apb(1'b1, ADDR_CTRL_FIRST, {25'h0, ch, 2'b01});
      repeat (ch == CHAN_TEMP ? 5000 : 50) @(posedge clk);
      apb(1'b1, ADDR_CTRL_FIRST, {25'h0, ch, 2'b11});
      apb(1'b0, ADDR_RESULT_HIGH, 32'h0);
      `CHK("result cleared", 32'h0, rdata)
      while (conv_irq !== 1'b1 && n < 200) begin
         n++;
         @(posedge clk);
      end
      `CHK("done interrupt", 1'b1, conv_irq)
      `CHK("wake flag", sleep_mode, wake)
      apb(1'b0, ADDR_RESULT_HIGH, 32'h0);
      `CHK("result high", {28'h0, exp[11:8]}, rdata)
      apb(1'b0, ADDR_RESULT_LOW, 32'h0);
      `CHK("result low", {24'h0, exp[7:0]}, rdata)
      apb(1'b0, ADDR_CTRL_FIRST, 32'h0);
      `CHK("go cleared", {25'h0, ch, 2'b01}, rdata)
      apb(1'b1, ADDR_FLAGS, 32'h3);
      @(posedge clk);
      `CHK("flags cleared", 2'b00, {conv_irq, wake})
   endtask : convert
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         stop_test();
      end
   end
   initial begin
      {rstn, psel, penable, pwrite, sleep_mode} = 5'b00000;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d);
         `CHK("write error", rows[i].err, rerr)
         apb(1'b0, rows[i].a, 32'h0);
         `CHK("read data", {24'h0, rows[i].rd}, rdata)
         `CHK("read error", rows[i].err, rerr)
         `CHK("mux and sensor ports", rows[i].port, port_vec)
      end
      $display("register table test done");
      apb(1'b1, ADDR_REF_TEMP, 32'hA0);
      foreach (chans[i]) convert(chans[i], {chans[i], 7'h2D});
      apb(1'b0, ADDR_REF_TEMP, 32'h0);
      `CHK("fixed ref ready", {1'b1, 32'hE0}, {fvr_en, rdata})
      $display("channel conversion test done");
      apb(1'b1, ADDR_CTRL_THIRD, 32'h3);
      convert(5'h08, 12'h3FD);
      apb(1'b1, ADDR_CTRL_THIRD, 32'hF);
      $display("differential test done");
      apb(1'b1, ADDR_CTRL_FIRST, 32'h27);
      repeat (20) @(posedge clk);
      apb(1'b1, ADDR_CTRL_FIRST, 32'h25);
      repeat (100) @(posedge clk);
      `CHK("abort interrupt", 1'b0, conv_irq)
      apb(1'b0, ADDR_RESULT_LOW, 32'h0);
      `CHK("abort discards partial", 32'h0, rdata)
      apb(1'b1, ADDR_CTRL_FIRST, 32'h26);
      repeat (80) @(posedge clk);
      `CHK("go without enable", 1'b0, conv_irq)
      apb(1'b0, ADDR_CTRL_FIRST, 32'h0);
      `CHK("go refused", 32'h24, rdata)
      $display("abort test done");
      sleep_mode <= 1'b1;
      convert(CHAN_TEMP, {CHAN_TEMP, 7'h2D});
      sleep_mode <= 1'b0;
      $display("sleep wake test done");
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      `CHK("ports after reset", {5'h00, 4'hF, 1'b1, 1'b0, 1'b0}, {pos_mux, neg_mux, single_ended, ts_power, conv_irq})
      apb(1'b0, ADDR_CTRL_THIRD, 32'h0);
      `CHK("third after reset", 32'h0F, rdata)
      apb(1'b0, ADDR_FLAGS, 32'h0);
      `CHK("flags after reset", 32'h04, rdata)
      $display("reset test done");
      stop_test();
   end
endmodule : acrc_tb_top
